//--- inc/cse_pkg.sv
// Overview of operation
// - Start one measurement per sample interval
// - Sample equals transfer pulses until trip
// - Finish streaming before next measurement starts
// - Polarity bit: 0 active low, 1 high
// - Function field picks latch or toggle
// - Active: output follows event, release held to minimum time
// - Latch: assert at least latch hold time
// - Toggle: invert output at each onset
// - Keep output asserted for minimum time
// - Proximity threshold 2, 4, 8, 16 counts
// - Proximity after six consecutive passing samples
// - Touch threshold is fraction of average
// - Touch after three consecutive passing samples
// - Touch select from bank0 7:6, bank1 0
// - Power mode sets 9/50/100/200 ms interval
// - Possible event zooms to boost rate
// - Persisting change recalibrates after halt interval
// - Average frozen during events unless halt is never; timer recalibrates
// - Halt select: 18.6 s, 74.5 s, never, always
// - Always: proximity 18.6 s, touch unlimited
package cse_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_DS = CLK_HZ / 10;
  localparam int unsigned BP_MS = 9, NP_MS = 50, LP1_MS = 100, LP2_MS = 200;
  // Halt intervals in tenths of a second
  localparam int unsigned HALT_A_DS = 186, HALT_B_DS = 745;
  localparam int unsigned LATCH_MS = 500, ZOOM_MS = 2000, MIN_ACT_MS = 1;
  localparam int unsigned XFER_DIV = 50;
  // ----------------------------------------
  // Widths and types
  // ----------------------------------------
  localparam int CS_W = 16, TMR_W = 32, XD_W = 6, DBC_W = 3;
  typedef logic [CS_W-1:0]  cse_cnt_t;
  typedef logic [TMR_W-1:0] cse_tmr_t;
  typedef enum logic [1:0] {OM_ACTIVE, OM_LATCH, OM_TOGGLE} cse_omode_e;
  typedef enum logic [1:0] {ST_IDLE, ST_CHARGE, ST_STREAM} cse_st_e;
  // ----------------------------------------
  // Detection and option fields
  // ----------------------------------------
  localparam int PROX_DEB = 6, TOUCH_DEB = 3, LTA_SHIFT = 4, TOUCH_THRESHOLD_SELECT_SHIFT = 5;
  localparam int PROXIMITY_THRESHOLD_SELECT_BASE = 2, EV_PROX = 0, EV_TOUCH = 1;
  localparam int B0_LOGIC = 1, B0_FUNC = 2, B0_PROXIMITY_THRESHOLD_SELECT = 4, B0_TOUCH_THRESHOLD_SELECT = 6;
  localparam int B1_TTHR2 = 0, B1_POWER_MODE_SELECT = 1, B1_HALT = 3, B1_STREAM = 7;
  localparam logic [1:0] PM_BOOST = 2'h0, PM_NORMAL = 2'h1, PM_LP1 = 2'h2;
  localparam logic [1:0] HALT_A = 2'h0, HALT_B = 2'h1, HALT_NEVER = 2'h2;
  localparam logic [1:0] HALT_ALWAYS = 2'h3;
  // ----------------------------------------
  // Register port
  // ----------------------------------------
  localparam int AW = 3, DW = 16;
  localparam logic [AW-1:0] RA_BANK0 = 3'h0, RA_BANK1 = 3'h1, RA_STATUS = 3'h2;
  localparam logic [AW-1:0] RA_SAMPLE = 3'h3, RA_AVG = 3'h4;
  localparam int SB_PROX = 0, SB_TOUCH = 1, SB_ZOOM = 2, SB_BUSY = 3;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic PIN_RST = 1'h1;  // Idle level of the default active-low setting
  function automatic cse_tmr_t to_cyc(input int unsigned n, input int unsigned per);
    return TMR_W'(longint'(n) * longint'(per));
  endfunction
endpackage

//--- inc/cse_smp_if.sv
`timescale 1ns/1ps
// Sample result handed from the core to the debouncers
interface cse_smp_if;
  logic       valid;  // One cycle per finished measurement
  logic [1:0] hit;    // Threshold passed, indexed by event
  modport src (output valid, output hit);
  modport snk (input valid, input hit);
endinterface

//--- logic/cse_debounce.sv
`timescale 1ns/1ps
module cse_debounce #(
  parameter int N   = 6,
  parameter int IDX = 0
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  cse_smp_if.snk    smp,
  output logic      ev_out
);
  import cse_pkg::*;
  logic [DBC_W-1:0] cnt_q, cnt_d;
  logic             ev_d;
  // Count passing samples; a single failure restarts the run
  always_comb begin
    cnt_d = cnt_q;
    ev_d  = ev_out;
    if (smp.valid && smp.hit[IDX]) begin
      if (cnt_q != DBC_W'(N)) cnt_d = cnt_q + DBC_W'(1);
      if (cnt_q >= DBC_W'(N - 1)) ev_d = 1'h1;
    end else if (smp.valid) begin
      cnt_d = '0;
      ev_d  = 1'h0;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q  <= '0;
      ev_out <= 1'h0;
    end else begin
      cnt_q  <= cnt_d;
      ev_out <= ev_d;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_fail;
    smp.valid && !smp.hit[IDX];
  endsequence
  property p_clear;
    s_fail |=> !ev_out && cnt_q == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("event held after failing sample");
  property p_onset;
    $rose(ev_out) |-> $past(cnt_q) >= DBC_W'(N - 1) && $past(smp.hit[IDX]);
  endproperty
  a_onset: assert property (p_onset) else $error("event raised too early");
endmodule

//--- logic/cse_out_drive.sv
`timescale 1ns/1ps
module cse_out_drive #(
  parameter cse_pkg::cse_tmr_t LATCH_CYC = 32'h0000_0010,
  parameter cse_pkg::cse_tmr_t MIN_CYC   = 32'h0000_0004
) (
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                ev_in,
  input  wire cse_pkg::cse_omode_e mode_in,
  input  wire logic                pol_in,
  output logic                     pin_out
);
  import cse_pkg::*;
  logic     ev_q, act_q, act_d, want, onset;
  cse_tmr_t lat_q, lat_d, hold_q, hold_d;
  // Wanted state per function, then the minimum active time gates release
  always_comb begin
    onset  = ev_in && !ev_q;
    lat_d  = (lat_q != '0) ? lat_q - TMR_W'(1) : lat_q;
    hold_d = (hold_q != '0) ? hold_q - TMR_W'(1) : hold_q;
    act_d  = act_q;
    unique case (mode_in)
      OM_LATCH: begin
        if (onset) lat_d = LATCH_CYC - TMR_W'(1);
        want = ev_in || lat_q != '0;
      end
      OM_TOGGLE: want = onset ? !act_q : act_q;
      default:   want = ev_in;
    endcase
    if (want && !act_q) begin
      act_d  = 1'h1;
      hold_d = MIN_CYC - TMR_W'(1);
    end else if (!want && act_q && hold_q == '0) begin
      act_d = 1'h0;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ev_q    <= 1'h0;
      act_q   <= 1'h0;
      lat_q   <= '0;
      hold_q  <= '0;
      pin_out <= PIN_RST;
    end else begin
      ev_q    <= ev_in;
      act_q   <= act_d;
      lat_q   <= lat_d;
      hold_q  <= hold_d;
      pin_out <= act_d ^ !pol_in;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_act;
    (mode_in == OM_ACTIVE && hold_q == '0) |=> act_q == $past(ev_in);
  endproperty
  a_act: assert property (p_act) else $error("active output not following event");
  property p_pol;
    1'h1 |=> pin_out == (act_q ^ !$past(pol_in));
  endproperty
  a_pol: assert property (p_pol) else $error("pin level wrong for polarity");
  property p_tog;
    (mode_in == OM_TOGGLE && onset && hold_q == '0) |=> act_q != $past(act_q);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle missed an onset");
  property p_lat;
    $fell(act_q) && $past(mode_in) == OM_LATCH |-> $past(lat_q) == '0;
  endproperty
  a_lat: assert property (p_lat) else $error("latch released early");
  property p_min;
    $fell(act_q) |-> $past(hold_q) == '0;
  endproperty
  a_min: assert property (p_min) else $error("output released before minimum time");
endmodule

//--- logic/cse_core.sv
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module cse_core #(
  parameter cse_pkg::cse_tmr_t BP_CYC  = cse_pkg::to_cyc(cse_pkg::BP_MS, cse_pkg::CYC_PER_MS),
  parameter cse_pkg::cse_tmr_t NP_CYC  = cse_pkg::to_cyc(cse_pkg::NP_MS, cse_pkg::CYC_PER_MS),
  parameter cse_pkg::cse_tmr_t LP1_CYC = cse_pkg::to_cyc(cse_pkg::LP1_MS, cse_pkg::CYC_PER_MS),
  parameter cse_pkg::cse_tmr_t LP2_CYC = cse_pkg::to_cyc(cse_pkg::LP2_MS, cse_pkg::CYC_PER_MS),
  parameter cse_pkg::cse_tmr_t HALT_A_CYC =
    cse_pkg::to_cyc(cse_pkg::HALT_A_DS, cse_pkg::CYC_PER_DS),
  parameter cse_pkg::cse_tmr_t HALT_B_CYC =
    cse_pkg::to_cyc(cse_pkg::HALT_B_DS, cse_pkg::CYC_PER_DS),
  parameter cse_pkg::cse_tmr_t LATCH_CYC =
    cse_pkg::to_cyc(cse_pkg::LATCH_MS, cse_pkg::CYC_PER_MS),
  parameter cse_pkg::cse_tmr_t ZOOM_CYC = cse_pkg::to_cyc(cse_pkg::ZOOM_MS, cse_pkg::CYC_PER_MS),
  parameter cse_pkg::cse_tmr_t MIN_CYC =
    cse_pkg::to_cyc(cse_pkg::MIN_ACT_MS, cse_pkg::CYC_PER_MS)
) (
  input  wire logic                   CLK_IN,
  input  wire logic                   RST_B_IN,
  input  wire logic [cse_pkg::AW-1:0] REG_ADDR_IN,
  input  wire logic [cse_pkg::DW-1:0] REG_WDATA_IN,
  input  wire logic                   REG_WR_IN,
  input  wire logic                   REG_RD_IN,
  output logic [cse_pkg::DW-1:0]      REG_RDATA_OUT,
  input  wire logic                   TRIP_IN,
  input  wire logic                   STREAM_DONE_IN,
  output logic                        CHARGE_EN_OUT,
  output logic                        XFER_PULSE_OUT,
  output logic                        STREAM_REQ_OUT,
  output logic                        PROXIMITY_OUTPUT_PIN_OUT,
  output logic                        TOUCH_OUTPUT_PIN_OUT
);
  import cse_pkg::*;

  localparam int TP_W = CS_W + 5;
  localparam cse_cnt_t CNT_MAX = '1;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Unsigned difference a - b with a sign bit on top
  function automatic logic signed [CS_W:0] sdiff(input cse_cnt_t a, input cse_cnt_t b);
    return $signed({1'h0, a}) - $signed({1'h0, b});
  endfunction

  // Touch fraction numerator over 32
  function automatic logic [4:0] tt_num(input logic [2:0] code);
    logic [4:0] n;
    n = 5'h00;
    unique case (code)
      3'h0: n = 5'h02;
      3'h1: n = 5'h01;
      3'h2: n = 5'h04;
      3'h3: n = 5'h06;
      3'h4: n = 5'h08;
      3'h5: n = 5'h0c;
      3'h6: n = 5'h10;
      3'h7: n = 5'h14;
    endcase
    return n;
  endfunction

  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  logic       rst_s1_q;
  logic       rst_n;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic       trip_s;
  logic       done_s;

  // Release reset through two flops so every flop leaves reset together
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_s1_q <= 1'h0;
      rst_n    <= 1'h0;
    end else begin
      rst_s1_q <= 1'h1;
      rst_n    <= rst_s1_q;
    end
  end

  // Front end and streamer run asynchronously to us
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
    end else begin
      pin_s1_q <= {STREAM_DONE_IN, TRIP_IN};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign trip_s = pin_s2_q[0];
  assign done_s = pin_s2_q[1];

  // ----------------------------------------
  // Option banks and register port
  // ----------------------------------------
  logic [7:0]    bank0_q, bank0_d;
  logic [7:0]    bank1_q, bank1_d;
  logic [DW-1:0] rdata_d;
  logic          pol;
  logic [1:0]    proximity_threshold_select;
  logic [2:0]    touch_threshold_select;
  logic [1:0]    power_mode_select;
  logic [1:0]    halt_sel;
  logic          stream_en;
  cse_omode_e    prox_mode;
  cse_omode_e    touch_mode;
  logic          ev_p;
  logic          ev_t;
  cse_st_e       st_q, st_d;
  cse_cnt_t      cs_q, cs_d;
  cse_cnt_t      lta_q, lta_d;
  cse_tmr_t      zoom_q, zoom_d;

  // Field decode of the two option banks
  assign pol       = bank0_q[B0_LOGIC];
  assign proximity_threshold_select      = bank0_q[B0_PROXIMITY_THRESHOLD_SELECT +: 2];
  assign touch_threshold_select      = {bank1_q[B1_TTHR2], bank0_q[B0_TOUCH_THRESHOLD_SELECT +: 2]};
  assign power_mode_select     = bank1_q[B1_POWER_MODE_SELECT +: 2];
  assign halt_sel  = bank1_q[B1_HALT +: 2];
  assign stream_en = bank1_q[B1_STREAM];
  // Low bit picks proximity latch, high bit touch toggle, each on its own pin
  assign prox_mode  = bank0_q[B0_FUNC] ? OM_LATCH : OM_ACTIVE;
  assign touch_mode = bank0_q[B0_FUNC + 1] ? OM_TOGGLE : OM_ACTIVE;

  // Writes land on the banks; reads return data in the next cycle only
  always_comb begin
    bank0_d = bank0_q;
    bank1_d = bank1_q;
    rdata_d = '0;
    if (REG_WR_IN && REG_ADDR_IN == RA_BANK0) bank0_d = REG_WDATA_IN[7:0];
    if (REG_WR_IN && REG_ADDR_IN == RA_BANK1) bank1_d = REG_WDATA_IN[7:0];
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        RA_BANK0:  rdata_d = DW'(bank0_q);
        RA_BANK1:  rdata_d = DW'(bank1_q);
        RA_STATUS: begin
          rdata_d[SB_PROX]  = ev_p;
          rdata_d[SB_TOUCH] = ev_t;
          rdata_d[SB_ZOOM]  = zoom_q != '0;
          rdata_d[SB_BUSY]  = st_q != ST_IDLE;
        end
        RA_SAMPLE: rdata_d = cs_q;
        RA_AVG:    rdata_d = lta_q;
        default:   rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      bank0_q       <= BANK_RST;
      bank1_q       <= BANK_RST;
      REG_RDATA_OUT <= '0;
    end else begin
      bank0_q       <= bank0_d;
      bank1_q       <= bank1_d;
      REG_RDATA_OUT <= rdata_d;
    end
  end

  // ----------------------------------------
  // Measurement scheduler
  // ----------------------------------------
  cse_tmr_t        tmr_q, tmr_d;
  cse_tmr_t        ivl;
  cse_cnt_t        cnt_q, cnt_d;
  logic [XD_W-1:0] xdiv_q, xdiv_d;
  logic            valid_q, valid_d;
  logic            xfer_d;
  logic [1:0]      hit;

  // Interval of the mode in force; zoom overrides with the boost rate
  always_comb begin
    unique case (power_mode_select)
      PM_BOOST:  ivl = BP_CYC;
      PM_NORMAL: ivl = NP_CYC;
      PM_LP1:    ivl = LP1_CYC;
      default:   ivl = LP2_CYC;
    endcase
    if (zoom_q != '0) ivl = BP_CYC;
  end

  // Interval timer free-runs so samples stay regular; a late start waits at zero
  always_comb begin
    st_d    = st_q;
    tmr_d   = (tmr_q != '0) ? tmr_q - TMR_W'(1) : tmr_q;
    cnt_d   = cnt_q;
    xdiv_d  = xdiv_q;
    cs_d    = cs_q;
    valid_d = 1'h0;
    xfer_d  = 1'h0;
    zoom_d  = (zoom_q != '0) ? zoom_q - TMR_W'(1) : zoom_q;
    unique case (st_q)
      ST_IDLE: begin
        if (tmr_q == '0) begin
          st_d   = ST_CHARGE;
          tmr_d  = ivl - TMR_W'(1);
          cnt_d  = '0;
          xdiv_d = '0;
        end
      end
      ST_CHARGE: begin
        xdiv_d = (xdiv_q == XD_W'(XFER_DIV - 1)) ? '0 : xdiv_q + XD_W'(1);
        // Saturated count ends a cycle whose trip never comes
        if (trip_s || cnt_q == CNT_MAX) begin
          cs_d    = cnt_q;
          valid_d = 1'h1;
          st_d    = stream_en ? ST_STREAM : ST_IDLE;
        end else if (xdiv_q == '0) begin
          xfer_d = 1'h1;
          cnt_d  = cnt_q + CS_W'(1);
        end
      end
      ST_STREAM: begin
        if (done_s) st_d = ST_IDLE;
      end
    endcase
    // A hopeful sample pulls the next start in to the boost rate
    if (valid_q && hit != 2'h0) begin
      zoom_d = ZOOM_CYC;
      if (tmr_d > BP_CYC) tmr_d = BP_CYC;
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      st_q           <= ST_IDLE;
      tmr_q          <= '0;
      cnt_q          <= '0;
      xdiv_q         <= '0;
      cs_q           <= '0;
      valid_q        <= 1'h0;
      zoom_q         <= '0;
      CHARGE_EN_OUT  <= 1'h0;
      XFER_PULSE_OUT <= 1'h0;
      STREAM_REQ_OUT <= 1'h0;
    end else begin
      st_q           <= st_d;
      tmr_q          <= tmr_d;
      cnt_q          <= cnt_d;
      xdiv_q         <= xdiv_d;
      cs_q           <= cs_d;
      valid_q        <= valid_d;
      zoom_q         <= zoom_d;
      CHARGE_EN_OUT  <= st_d == ST_CHARGE;
      XFER_PULSE_OUT <= xfer_d;
      STREAM_REQ_OUT <= st_d == ST_STREAM;
    end
  end

  // ----------------------------------------
  // Threshold compare and average filter
  // ----------------------------------------
  logic                   init_q, init_d;
  logic signed [CS_W:0]   drop;
  cse_cnt_t               proximity_threshold_select_val;
  cse_cnt_t               touch_threshold_select_val;
  cse_tmr_t               htmr_q, htmr_d;
  cse_tmr_t               hlim;
  logic                   halted;
  logic                   recal;
  cse_smp_if              smp ();

  // Drop of the sample below the average against both thresholds
  always_comb begin
    drop     = sdiff(lta_q, cs_q);
    proximity_threshold_select_val = CS_W'(PROXIMITY_THRESHOLD_SELECT_BASE) << proximity_threshold_select;
    touch_threshold_select_val = CS_W'((TP_W'(lta_q) * TP_W'(tt_num(touch_threshold_select))) >> TOUCH_THRESHOLD_SELECT_SHIFT);
    hit[EV_PROX]  = init_q && !drop[CS_W] && drop[CS_W-1:0] >= proximity_threshold_select_val;
    hit[EV_TOUCH] = init_q && !drop[CS_W] && drop[CS_W-1:0] >= touch_threshold_select_val;
  end
  assign smp.valid = valid_q;
  assign smp.hit   = hit;

  // Halt timer runs from event onset; expiry snaps the average to the sample
  always_comb begin
    hlim   = (halt_sel == HALT_B) ? HALT_B_CYC : HALT_A_CYC;
    halted = (ev_p || ev_t) && halt_sel != HALT_NEVER;
    recal  = halted && htmr_q == hlim - TMR_W'(1) &&
             !(halt_sel == HALT_ALWAYS && ev_t);
    htmr_d = htmr_q;
    if (!halted) htmr_d = '0;
    else if (htmr_q != hlim) htmr_d = htmr_q + TMR_W'(1);
    lta_d  = lta_q;
    init_d = init_q;
    if (recal) begin
      lta_d = cs_q;
    end else if (valid_q && !init_q) begin
      lta_d  = cs_q;
      init_d = 1'h1;
    end else if (valid_q && !halted) begin
      lta_d = lta_q + CS_W'(sdiff(cs_q, lta_q) >>> LTA_SHIFT);
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      lta_q  <= '0;
      init_q <= 1'h0;
      htmr_q <= '0;
    end else begin
      lta_q  <= lta_d;
      init_q <= init_d;
      htmr_q <= htmr_d;
    end
  end

  // ----------------------------------------
  // Event debounce and output pins
  // ----------------------------------------
  cse_debounce #(.N(PROX_DEB), .IDX(EV_PROX)) u_deb_prox (
    .clk_in   (CLK_IN),
    .rst_n_in (rst_n),
    .smp      (smp.snk),
    .ev_out   (ev_p)
  );
  cse_debounce #(.N(TOUCH_DEB), .IDX(EV_TOUCH)) u_deb_touch (
    .clk_in   (CLK_IN),
    .rst_n_in (rst_n),
    .smp      (smp.snk),
    .ev_out   (ev_t)
  );
  cse_out_drive #(.LATCH_CYC(LATCH_CYC), .MIN_CYC(MIN_CYC)) u_out_prox (
    .clk_in   (CLK_IN),
    .rst_n_in (rst_n),
    .ev_in    (ev_p),
    .mode_in  (prox_mode),
    .pol_in   (pol),
    .pin_out  (PROXIMITY_OUTPUT_PIN_OUT)
  );
  cse_out_drive #(.LATCH_CYC(LATCH_CYC), .MIN_CYC(MIN_CYC)) u_out_touch (
    .clk_in   (CLK_IN),
    .rst_n_in (rst_n),
    .ev_in    (ev_t),
    .mode_in  (touch_mode),
    .pol_in   (pol),
    .pin_out  (TOUCH_OUTPUT_PIN_OUT)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n);

  property p_start;
    (st_q == ST_IDLE && tmr_q == '0 && !valid_q) |=>
      st_q == ST_CHARGE && tmr_q == $past(ivl) - TMR_W'(1);
  endproperty
  a_start: assert property (p_start) else $error("measurement not started on time");

  property p_cs;
    (st_q == ST_CHARGE && trip_s) |=> valid_q && cs_q == $past(cnt_q);
  endproperty
  a_cs: assert property (p_cs) else $error("sample differs from pulse count");

  sequence s_streaming;
    st_q == ST_STREAM && !done_s;
  endsequence
  property p_stream;
    s_streaming |=> st_q == ST_STREAM && STREAM_REQ_OUT;
  endproperty
  a_stream: assert property (p_stream) else $error("left streaming too early");

  property p_zoom;
    (valid_q && hit != 2'h0) |=> zoom_q == ZOOM_CYC && tmr_q <= BP_CYC;
  endproperty
  a_zoom: assert property (p_zoom) else $error("zoom not entered");

  property p_halt;
    (valid_q && halted && !recal && init_q) |=> lta_q == $past(lta_q);
  endproperty
  a_halt: assert property (p_halt) else $error("average moved during event");

  property p_recal;
    recal |=> lta_q == $past(cs_q) && $past(htmr_q) == $past(hlim) - TMR_W'(1);
  endproperty
  a_recal: assert property (p_recal) else $error("recalibration wrong");
endmodule

//--- verif/cse_fe_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far side: sense front end and a slow streamer
// ----------------------------------------
module cse_fe_model (
  input  wire logic        clk_in,
  input  wire logic        chg_in,
  input  wire logic        xfer_in,
  input  wire logic        req_in,
  input  wire logic [15:0] cnt_in,
  output logic             trip_out = 1'b0,
  output logic             done_out = 1'b0
);
  int np  = 0;
  int dly = 0;
  // Trip after the set number of transfers; discharge while charge is off
  always @(posedge clk_in) begin
    if (!chg_in) begin
      np       <= 0;
      trip_out <= 1'b0;
    end else if (xfer_in) begin
      np       <= np + 1;
      trip_out <= (np + 1 >= int'(cnt_in));
    end
  end
  // Done comes late on purpose, so the core must really wait for it
  always @(posedge clk_in) begin
    dly      <= req_in ? dly + 1 : 0;
    done_out <= req_in && dly >= 6;
  end
endmodule

//--- verif/cse_core_tb.sv
`timescale 1ns/1ps
module cse_core_tb;
  import cse_pkg::*;
  logic          clk;
  logic          rst_b;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          wr;
  logic          rd;
  logic          rd_q;
  logic [DW-1:0] rdata;
  logic          trip, done, chg, xfer, sreq, ppin, tpin;
  logic [15:0]   tgt;
  logic [31:0]   exp_q[$];
  logic [1:0]    pin_q[$];
  int            failures;
  int            check_count;
  int            base;

  // Short counts keep the run brief
  // Only the boost rate is used, so the slower intervals keep their defaults
  cse_core #(.BP_CYC(200), .HALT_A_CYC(30000), .LATCH_CYC(50), .ZOOM_CYC(2000),
    .MIN_CYC(5)) dut (
    .CLK_IN(clk), .RST_B_IN(rst_b), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .TRIP_IN(trip),
    .STREAM_DONE_IN(done), .CHARGE_EN_OUT(chg), .XFER_PULSE_OUT(xfer),
    .STREAM_REQ_OUT(sreq), .PROXIMITY_OUTPUT_PIN_OUT(ppin),
    .TOUCH_OUTPUT_PIN_OUT(tpin));
  cse_fe_model fe (.clk_in(clk), .chg_in(chg), .xfer_in(xfer), .req_in(sreq),
    .cnt_in(tgt), .trip_out(trip), .done_out(done));

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pin pair compare, proximity in the high bit
  task automatic cmp_pin(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t pins got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [AW-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= {8'h00, d};
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Expected value and mask go on the queue for the monitor
  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] e,
                        input logic [DW-1:0] m);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q && exp_q.size() > 0) begin
      logic [31:0] n;
      n = exp_q.pop_front();
      cmp(rdata & n[31:16], n[15:0]);
    end
  end

  // One edge first, so a polarity write has reached the pin flops
  task automatic pins(input logic p, input logic t);
    @(posedge clk);
    pin_q.push_back({p, t});
  endtask

  // Pins are looked at on the falling edge, well away from their launch
  always @(negedge clk) begin
    if (pin_q.size() > 0) begin
      logic [1:0] e;
      e = pin_q.pop_front();
      cmp_pin({ppin, tpin}, e);
    end
  end

  // Count only changes while no charge runs, so each sample is whole
  task automatic run(input int n, input int c);
    int k;
    k = 0;
    if (c[15:0] != tgt) begin
      while (chg !== 1'b0 && k < 9000) begin
        @(negedge clk);
        k++;
      end
      @(posedge clk);
      tgt <= c[15:0];
    end
    repeat (n) begin
      while (chg !== 1'b1 && k < 20000) begin
        @(negedge clk);
        k++;
      end
      while (chg !== 1'b0 && k < 20000) begin
        @(negedge clk);
        k++;
      end
    end
    if (k >= 20000)
      failures++;
    repeat (6) @(posedge clk);
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #1_000_000;
    failures++;
    give_verdict();
  end

  // Main sequence
  initial begin
    void'($urandom(11176));
    base = 32 + int'($urandom % 8);
    {rst_b, wr, rd, addr, wdata} = '0;
    // The very first sample seeds the average, so it must be a resting one
    tgt = base[15:0];
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(RA_BANK0, 16'h0000, 16'hFFFF);
    rd_chk(3'h5, 16'h0000, 16'hFFFF);
    reg_wr(RA_BANK0, 8'hC0);
    reg_wr(RA_BANK1, 8'h81);
    pins(1'b1, 1'b1);
    run(4, base);
    rd_chk(RA_SAMPLE, DW'(base), 16'hFFFF);
    run(5, base - 10);
    rd_chk(RA_STATUS, 16'h0000, 16'h0003);
    run(1, base - 10);
    rd_chk(RA_STATUS, 16'h0005, 16'h0007);
    pins(1'b0, 1'b1);
    run(2, 2);
    rd_chk(RA_STATUS, 16'h0001, 16'h0003);
    run(1, 2);
    rd_chk(RA_STATUS, 16'h0003, 16'h0003);
    pins(1'b0, 1'b0);
    run(1, base);
    rd_chk(RA_STATUS, 16'h0000, 16'h0003);
    pins(1'b1, 1'b1);
    reg_wr(RA_BANK0, 8'hCA);
    pins(1'b0, 1'b0);
    run(3, 2);
    pins(1'b0, 1'b1);
    run(1, base);
    pins(1'b0, 1'b1);
    reg_wr(RA_BANK0, 8'hCE);
    run(3, 2);
    pins(1'b0, 1'b0);
    run(3, 2);
    pins(1'b1, 1'b0);
    run(1, base);
    pins(1'b0, 1'b0);
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule
